// File: logic/alarm_pkg.sv
// Constants shared by the alarm aggregator: register map, pin layout, timing
package alarm_pkg;
    // Register byte offsets
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] LEVELS_OFFSET = 4'h8;
    // Control register fields
    localparam int DUAL_CPU_BIT = 0;
    localparam int THRESH_LSB = 8;
    localparam int THRESH_W = 8;
    // Values after reset
    localparam logic DUAL_CPU_RESET = 1'b1;
    localparam logic [7:0] THRESH_RESET = 8'h50;
    // Relay count and fault source positions
    localparam int RELAY_N = 2;
    localparam int SRC_N = 5;
    localparam int SRC_SUP1 = 0;
    localparam int SRC_SUP2 = 1;
    localparam int SRC_CPU = 2;
    localparam int SRC_FAN = 3;
    localparam int SRC_FRAME = 4;
    // Pin vector layout, all taken from outside the clock domain
    localparam int PIN_SUP1_LOW = 0;
    localparam int PIN_SUP2_LOW = 1;
    localparam int PIN_CPU_HOT = 2;
    localparam int PIN_CPU_A = 3;
    localparam int PIN_CPU_B = 4;
    localparam int PIN_FAN1_STOP = 5;
    localparam int PIN_FAN2_STOP = 6;
    localparam int PIN_SUP_HOT = 7;
    localparam int PIN_ACK = 8;
    localparam int PIN_RAIL_LSB = 9;
    localparam int RAIL_N = 4;
    localparam int PIN_TEMP_LSB = 13;
    localparam int TEMP_W = 8;
    localparam int PIN_W = 21;
    // Flash timing: half period of the main lamp blink
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// File: logic/alarm_aggregator.sv
// Frame alarm aggregation, acknowledge handling, lamps, relays and fans
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// How it works
// - Either supply unit low raises alarm
// - CPU overheat or card removal raises alarm
// - Either cooling fan stopped raises alarm
// - Frame temperature above threshold raises alarm
// - Alarm flashes main lamp, sounds buzzer
// - Alarm drives all relay outputs active
// - Four cause lamps show alarm source
// - Acknowledge silences buzzer despite fault
// - Acknowledge releases all alarm relays
// - Main lamp flashes until originals clear
// - New faults silent until originals clear
// - Outside-alarm lamp follows active relays
// - Temperature lamp: CPU overheat or removal
// - Removal detected only with two cards
// - Fan-fail lamp when either fan stops
// - Supply fail lamp follows its unit
// - Primary fan running except during reset
// - Supply overheat switches second fan on
// - Fan-on lamp while second fan runs
// - Rail-good lamps follow rail presence
module alarm_aggregator #(
    parameter int FLASH_HALF = alarm_pkg::FLASH_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply1_low,
    input wire logic supply2_low,
    input wire logic cpu_overtemp,
    input wire logic cpu_a_present,
    input wire logic cpu_b_present,
    input wire logic fan1_stopped,
    input wire logic fan2_stopped,
    input wire logic supply_overtemp,
    input wire logic ack_button,
    input wire logic [alarm_pkg::RAIL_N-1:0] rail_present,
    input wire logic [alarm_pkg::TEMP_W-1:0] frame_temp,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic main_alarm_lamp,
    output logic buzzer,
    output logic [alarm_pkg::RELAY_N-1:0] alarm_relay,
    output logic outside_alarm_lamp,
    output logic temp_lamp,
    output logic fan_fail_lamp,
    output logic first_supply_fail_lamp,
    output logic second_supply_fail_lamp,
    output logic fan_on_lamp,
    output logic primary_fan_on,
    output logic second_fan_on,
    output logic [alarm_pkg::RAIL_N-1:0] rail_good_lamp
);
    import alarm_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [PIN_W-1:0] s1;         // First sync stage, read only by s2
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] stab;       // Accepted level once s2 and s3 agree
        logic ack_prev;               // For acknowledge edge
        logic silenced;               // Acknowledged, waiting for originals
        logic [SRC_N-1:0] orig;       // Sources latched at acknowledge
        logic [31:0] flash_cnt;
        logic flash_ph;
        logic dual_cpu;
        logic [THRESH_W-1:0] thresh;
        logic wreq;                   // Waitrequest, low for one answer cycle
        logic [31:0] rdata;
        logic main_lamp;
        logic buzz;
        logic [RELAY_N-1:0] relay;
        logic outside_lamp;
        logic temp_l;
        logic fan_fail_l;
        logic sup1_l;
        logic sup2_l;
        logic fan_on_l;
        logic fan1_on;
        logic fan2_on;
        logic [RAIL_N-1:0] rail_l;
    } state_t;

    state_t st_r;   // Registered state
    state_t st_nxt; // Next state

    // Pin vector gathered in package layout
    // Bit order here must match the package pin positions
    logic [PIN_W-1:0] pins;
    assign pins = {frame_temp, rail_present, ack_button, supply_overtemp, fan2_stopped,
        fan1_stopped, cpu_b_present, cpu_a_present, cpu_overtemp, supply2_low, supply1_low};

    // Fault decode from accepted levels
    logic cpu_removed;
    logic frame_hot;
    logic [SRC_N-1:0] faults;
    logic any_fault;
    logic ack_edge;
    logic req;
    logic [31:0] status_word;
    logic [31:0] control_word;
    logic [31:0] levels_word;

    always_comb begin
        // Removal only counts when two cards are declared fitted
        cpu_removed = st_r.dual_cpu &
            (~st_r.stab[PIN_CPU_A] | ~st_r.stab[PIN_CPU_B]);
        frame_hot = st_r.stab[PIN_TEMP_LSB +: TEMP_W] > st_r.thresh;
        faults = '0;
        faults[SRC_SUP1] = st_r.stab[PIN_SUP1_LOW];
        faults[SRC_SUP2] = st_r.stab[PIN_SUP2_LOW];
        faults[SRC_CPU] = st_r.stab[PIN_CPU_HOT] | cpu_removed;
        faults[SRC_FAN] = st_r.stab[PIN_FAN1_STOP] | st_r.stab[PIN_FAN2_STOP];
        faults[SRC_FRAME] = frame_hot;
        any_fault = |faults;
        ack_edge = st_r.stab[PIN_ACK] & ~st_r.ack_prev;
        req = avs_read | avs_write;
    end

    // Register views
    // Status bits 0-4 are live faults, bits 8-12 hold the original set, bits 16-19 show silence, buzzer, lamp and fan
    always_comb begin
        control_word = '0;
        control_word[DUAL_CPU_BIT] = st_r.dual_cpu;
        control_word[THRESH_LSB +: THRESH_W] = st_r.thresh;
        status_word = '0;
        status_word[SRC_N-1:0] = faults;
        status_word[8 +: SRC_N] = st_r.orig;
        status_word[16] = st_r.silenced;
        status_word[17] = st_r.buzz;
        status_word[18] = st_r.main_lamp;
        status_word[19] = st_r.fan2_on;
        levels_word = '0;
        levels_word[PIN_W-1:0] = st_r.stab;
    end

    // Next state
    always_comb begin
        st_nxt = st_r;

        // Three-stage sync, accept a bit once stages two and three agree
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.stab = (st_r.s2 & st_r.s3) | (st_r.stab & (st_r.s2 | st_r.s3));
        st_nxt.ack_prev = st_r.stab[PIN_ACK];

        // Acknowledge and original-source tracking
        if (st_r.silenced) begin
            // Originals drop out one by one as they clear
            st_nxt.orig = st_r.orig & faults;
            if ((st_r.orig & faults) == '0) begin
                st_nxt.silenced = 1'b0;
            end
        end else if (ack_edge && any_fault) begin
            // Acknowledge with no alarm present is ignored
            st_nxt.silenced = 1'b1;
            st_nxt.orig = faults;
        end

        // Free-running blink so all flashing lamps share one phase
        // A lamp that lights mid-phase may show a short first flash
        if (st_r.flash_cnt >= 32'(FLASH_HALF - 1)) begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash_ph = ~st_r.flash_ph;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 32'h0000_0001;
        end

        // Main lamp: original sources while silenced, any fault otherwise
        st_nxt.main_lamp = st_nxt.flash_ph &
            (st_nxt.silenced ? (|st_nxt.orig) : any_fault);
        // Buzzer and relays only while not silenced
        st_nxt.buzz = ~st_nxt.silenced & any_fault;
        st_nxt.relay = {RELAY_N{~st_nxt.silenced & any_fault}};
        st_nxt.outside_lamp = ~st_nxt.silenced & any_fault;
        st_nxt.temp_l = faults[SRC_CPU];
        st_nxt.fan_fail_l = faults[SRC_FAN];
        st_nxt.sup1_l = faults[SRC_SUP1];
        st_nxt.sup2_l = faults[SRC_SUP2];
        st_nxt.fan1_on = 1'b1;
        st_nxt.fan2_on = st_r.stab[PIN_SUP_HOT];
        st_nxt.fan_on_l = st_r.stab[PIN_SUP_HOT];
        st_nxt.rail_l = st_r.stab[PIN_RAIL_LSB +: RAIL_N];

        // Avalon slave: one wait cycle, answer in the next
        // Fixed latency keeps the master simple, no further back-pressure
        // Requests are taken only while waitrequest is high
        if (!st_r.wreq) begin
            st_nxt.wreq = 1'b1;
            // Write lands on the edge the master sees waitrequest low
            if (avs_write && avs_address == CONTROL_OFFSET) begin
                if (avs_byteenable[0]) begin
                    st_nxt.dual_cpu = avs_writedata[DUAL_CPU_BIT];
                end
                if (avs_byteenable[1]) begin
                    st_nxt.thresh = avs_writedata[THRESH_LSB +: THRESH_W];
                end
            end
        end else if (req) begin
            st_nxt.wreq = 1'b0;
            // Unmapped addresses read zero, writes there are dropped
            if (avs_address == CONTROL_OFFSET) begin
                st_nxt.rdata = control_word;
            end else if (avs_address == STATUS_OFFSET) begin
                st_nxt.rdata = status_word;
            end else if (avs_address == LEVELS_OFFSET) begin
                st_nxt.rdata = levels_word;
            end else begin
                st_nxt.rdata = '0;
            end
        end
    end

    // State register, synchronous reset clears all alarm and lamp state
    // Control register returns to its defaults with every reset
    // Presence bits read absent for a few cycles after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.dual_cpu <= DUAL_CPU_RESET;
            st_r.thresh <= THRESH_RESET;
            st_r.wreq <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flip-flops
    // Nothing is decoded on the way out, so lamps never glitch
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.wreq;
    assign main_alarm_lamp = st_r.main_lamp;
    assign buzzer = st_r.buzz;
    assign alarm_relay = st_r.relay;
    assign outside_alarm_lamp = st_r.outside_lamp;
    assign temp_lamp = st_r.temp_l;
    assign fan_fail_lamp = st_r.fan_fail_l;
    assign first_supply_fail_lamp = st_r.sup1_l;
    assign second_supply_fail_lamp = st_r.sup2_l;
    assign fan_on_lamp = st_r.fan_on_l;
    assign primary_fan_on = st_r.fan1_on;
    assign second_fan_on = st_r.fan2_on;
    assign rail_good_lamp = st_r.rail_l;

    // Checks on the alarm behaviour
    a_supply_alarm: assert property (@(posedge clk) disable iff (rst)
        (faults[SRC_SUP1] && !st_r.silenced && !ack_edge) |=> buzzer)
        else $error("supply fault did not sound buzzer");

    a_cpu_removal: assert property (@(posedge clk) disable iff (rst)
        (!st_r.dual_cpu && !st_r.stab[PIN_CPU_HOT]) |=> !temp_lamp)
        else $error("temperature lamp lit with single card");

    a_relay_buzz: assert property (@(posedge clk) disable iff (rst)
        alarm_relay == {RELAY_N{buzzer}} && outside_alarm_lamp == buzzer)
        else $error("relays, buzzer and outside lamp disagree");

    a_ack_silence: assert property (@(posedge clk) disable iff (rst)
        (ack_edge && any_fault && !st_r.silenced) |=> (!buzzer && alarm_relay == '0))
        else $error("acknowledge did not silence buzzer and relays");

    a_silent_hold: assert property (@(posedge clk) disable iff (rst)
        (st_r.silenced && (st_r.orig & faults) != '0) |=> (!buzzer && st_r.silenced))
        else $error("buzzer returned before originals cleared");

    a_lamp_flash: assert property (@(posedge clk) disable iff (rst)
        main_alarm_lamp |-> (st_r.flash_ph && (st_r.silenced ? |st_r.orig : 1'b1)))
        else $error("main lamp lit outside flash phase");

    a_second_fan: assert property (@(posedge clk) disable iff (rst)
        $rose(st_r.stab[PIN_SUP_HOT]) |=> (second_fan_on && fan_on_lamp))
        else $error("second fan or its lamp did not follow overheat");

    a_primary_fan: assert property (@(posedge clk) disable iff (rst)
        $past(!rst) |-> primary_fan_on)
        else $error("primary fan stopped");

    a_sync_accept: assert property (@(posedge clk) disable iff (rst)
        (st_r.s2[PIN_ACK] == st_r.s3[PIN_ACK]) |=> st_r.stab[PIN_ACK] == $past(st_r.s3[PIN_ACK]))
        else $error("agreed sync stages not accepted");

    a_rail_lamp: assert property (@(posedge clk) disable iff (rst)
        ##1 rail_good_lamp == $past(st_r.stab[PIN_RAIL_LSB +: RAIL_N]))
        else $error("rail lamp does not follow rail");

    // Lamp copies are checked only from the second cycle after reset,
    // since the first output update still comes from the reset state.
    // Antecedents that the reset state can make true carry a !rst term,
    // as the edge that leaves reset still samples it high.

    // Second supply unit low sounds the buzzer like the first
    a_supply2_alarm: assert property (@(posedge clk) disable iff (rst)
        (st_r.stab[PIN_SUP2_LOW] && !st_r.silenced && !ack_edge) |=> buzzer)
        else $error("second supply fault did not sound buzzer");

    // Processor overheat raises the alarm
    a_cpu_alarm: assert property (@(posedge clk) disable iff (rst)
        (st_r.stab[PIN_CPU_HOT] && !st_r.silenced && !ack_edge) |=> buzzer)
        else $error("processor overheat did not sound buzzer");

    // Either stopped fan raises the alarm
    a_fan_alarm: assert property (@(posedge clk) disable iff (rst)
        ((st_r.stab[PIN_FAN1_STOP] || st_r.stab[PIN_FAN2_STOP])
            && !st_r.silenced && !ack_edge) |=> buzzer)
        else $error("stopped fan did not sound buzzer");

    // Frame above threshold energises every relay
    a_frame_alarm: assert property (@(posedge clk) disable iff (rst)
        ((st_r.stab[PIN_TEMP_LSB +: TEMP_W] > st_r.thresh) && !st_r.silenced && !ack_edge)
            |=> alarm_relay == {RELAY_N{1'b1}})
        else $error("frame overheat did not drive relays");

    // Any fault while not silenced lights the main lamp in the lit phase
    a_alarm_lamp: assert property (@(posedge clk) disable iff (rst)
        (!rst && any_fault && !st_r.silenced && st_nxt.flash_ph) |=> main_alarm_lamp)
        else $error("main lamp dark during alarm");

    // Acknowledge with nothing wrong leaves the block armed
    a_ack_ignored: assert property (@(posedge clk) disable iff (rst)
        (ack_edge && !any_fault && !st_r.silenced) |=> !st_r.silenced)
        else $error("acknowledge without fault silenced the block");

    // Relays stay released for the whole silenced period
    a_relay_release: assert property (@(posedge clk) disable iff (rst)
        st_r.silenced |-> (alarm_relay == '0 && !buzzer))
        else $error("relay active while silenced");

    // Originals still present keep the lamp flashing
    a_orig_flash: assert property (@(posedge clk) disable iff (rst)
        (st_r.silenced && (st_r.orig & faults) != '0 && st_nxt.flash_ph) |=> main_alarm_lamp)
        else $error("main lamp dark while originals remain");

    // No fault and not silenced means a dark main lamp
    a_lamp_quiet: assert property (@(posedge clk) disable iff (rst)
        (!st_r.silenced && !any_fault) |=> !main_alarm_lamp)
        else $error("main lamp lit with no fault");

    // Once originals clear, a remaining new fault sounds again
    a_silence_end: assert property (@(posedge clk) disable iff (rst)
        (st_r.silenced && (st_r.orig & faults) == '0 && any_fault) |=> buzzer)
        else $error("new fault silent after originals cleared");

    // Outside lamp only with relays energised
    a_outside_lamp: assert property (@(posedge clk) disable iff (rst)
        outside_alarm_lamp |-> (alarm_relay == {RELAY_N{1'b1}}))
        else $error("outside lamp lit with relays idle");

    // Temperature lamp follows overheat or removal
    a_temp_lamp: assert property (@(posedge clk) disable iff (rst)
        $past(!rst) |-> temp_lamp == $past(st_r.stab[PIN_CPU_HOT] | cpu_removed))
        else $error("temperature lamp wrong");

    // Fan-fail lamp follows either stopped fan
    a_fan_fail_lamp: assert property (@(posedge clk) disable iff (rst)
        $past(!rst) |-> fan_fail_lamp ==
            $past(st_r.stab[PIN_FAN1_STOP] | st_r.stab[PIN_FAN2_STOP]))
        else $error("fan-fail lamp wrong");

    // Each supply lamp follows its own unit
    a_supply_lamps: assert property (@(posedge clk) disable iff (rst)
        $past(!rst) |-> (first_supply_fail_lamp == $past(st_r.stab[PIN_SUP1_LOW])
            && second_supply_fail_lamp == $past(st_r.stab[PIN_SUP2_LOW])))
        else $error("supply fail lamp wrong");

    // Second fan stops once no unit is hot
    a_fan2_off: assert property (@(posedge clk) disable iff (rst)
        !st_r.stab[PIN_SUP_HOT] |=> !second_fan_on)
        else $error("second fan on without overheat");

    // Fan-on lamp and second fan always agree
    a_fan_lamp: assert property (@(posedge clk) disable iff (rst)
        fan_on_lamp == second_fan_on)
        else $error("fan-on lamp disagrees with second fan");
endmodule

// File: verif/frame_partner.sv
// Behavioural frame hardware: supply units, fans, CPU cards and sensors behind the fault pins
`timescale 1ns/1ps
module frame_partner (
    input wire logic clk,
    input wire logic [alarm_pkg::PIN_W-1:0] cmd,
    output logic [alarm_pkg::PIN_W-1:0] pins = '0
);
    import alarm_pkg::*;
    // Physical condition follows the bench command one clock later
    // Pins never float: every bit is driven from time zero on
    always @(posedge clk) begin
        pins <= cmd;
    end
endmodule

// File: verif/alarm_aggregator_tb.sv
// Self-checking bench for the frame alarm aggregator
`timescale 1ns/1ps
module alarm_aggregator_tb;
    import alarm_pkg::*;
    localparam int HALF = 4; // Short blink so a flash fits in the history window
    logic clk = 1'b0; // System clock
    logic rst = 1'b1; // Held for ten cycles at start
    logic [PIN_W-1:0] pin_cmd = '0; // Commanded hardware state
    logic [PIN_W-1:0] pins; // Pins as the frame model drives them
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, main_alarm_lamp, buzzer, outside_alarm_lamp, temp_lamp;
    logic fan_fail_lamp, first_supply_fail_lamp, second_supply_fail_lamp, fan_on_lamp;
    logic primary_fan_on, second_fan_on;
    logic [RELAY_N-1:0] alarm_relay;
    logic [RAIL_N-1:0] rail_good_lamp;
    int failures = 0; // Mismatches seen
    int total_checks = 0; // Comparisons made
    int cycles = 0; // Timeout counter
    logic chk_req = 1'b0; // Asks the watcher to compare now
    logic [9:0] hist = 10'h0; // Recent main lamp samples, to see a blink
    logic [33:0] pq[$]; // Expected {mask, value} of the outputs
    logic [31:0] rq[$]; // Expected read data
    logic [33:0] ent;
    logic [31:0] seed = 32'hF6A6;
    logic [16:0] obs;
    int src[5] = '{PIN_SUP1_LOW, PIN_SUP2_LOW, PIN_CPU_HOT, PIN_FAN1_STOP, PIN_FAN2_STOP};
    logic [4:0] lmp[5] = '{5'h04, 5'h02, 5'h10, 5'h08, 5'h08}; // temp,fanfail,s1,s2,fanon
    // Blink shows as some but not all history bits set
    assign obs = {|hist, &hist, buzzer, alarm_relay, outside_alarm_lamp, temp_lamp,
        fan_fail_lamp, first_supply_fail_lamp, second_supply_fail_lamp, fan_on_lamp,
        primary_fan_on, second_fan_on, rail_good_lamp};
    // Clock generator
    always #5 clk = ~clk;
    frame_partner frame_partner_i (.clk(clk), .cmd(pin_cmd), .pins(pins));
    alarm_aggregator #(.FLASH_HALF(HALF)) alarm_aggregator_i (
        .clk(clk), .rst(rst), .supply1_low(pins[PIN_SUP1_LOW]),
        .supply2_low(pins[PIN_SUP2_LOW]), .cpu_overtemp(pins[PIN_CPU_HOT]),
        .cpu_a_present(pins[PIN_CPU_A]), .cpu_b_present(pins[PIN_CPU_B]),
        .fan1_stopped(pins[PIN_FAN1_STOP]), .fan2_stopped(pins[PIN_FAN2_STOP]),
        .supply_overtemp(pins[PIN_SUP_HOT]), .ack_button(pins[PIN_ACK]),
        .rail_present(pins[PIN_RAIL_LSB +: RAIL_N]), .frame_temp(pins[PIN_TEMP_LSB +: TEMP_W]),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_alarm_lamp(main_alarm_lamp), .buzzer(buzzer), .alarm_relay(alarm_relay),
        .outside_alarm_lamp(outside_alarm_lamp), .temp_lamp(temp_lamp),
        .fan_fail_lamp(fan_fail_lamp), .first_supply_fail_lamp(first_supply_fail_lamp),
        .second_supply_fail_lamp(second_supply_fail_lamp), .fan_on_lamp(fan_on_lamp),
        .primary_fan_on(primary_fan_on), .second_fan_on(second_fan_on),
        .rail_good_lamp(rail_good_lamp));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Expected outputs: flashing, loud (buzzer, relays, outside lamp), cause lamps, second fan
    function automatic logic [16:0] ex(input logic fl, input logic ld, input logic [4:0] lp,
            input logic sf);
        return {fl, 1'b0, ld, {2{ld}}, ld, lp, 1'b1, sf, pin_cmd[PIN_RAIL_LSB +: RAIL_N]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One Avalon transfer; waits for waitrequest low with no bound of its own, only the watcher timeout
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] be, input logic [31:0] e);
        if (!wr) rq.push_back(e);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // Change one pin with fresh random rails, then let sync and blink history settle
    task automatic drive(input int idx, input logic v);
        seed = xs(seed);
        pin_cmd[idx] <= v;
        pin_cmd[PIN_RAIL_LSB +: RAIL_N] <= seed[3:0];
        repeat (16) @(posedge clk);
    endtask
    task automatic expect_now(input logic [16:0] m, input logic [16:0] e);
        pq.push_back({m, e});
        chk_req <= 1'b1;
        @(posedge clk);
        chk_req <= 1'b0;
    endtask
    task automatic ack();
        drive(PIN_ACK, 1'b1);
        drive(PIN_ACK, 1'b0);
    endtask
    // Watcher: compares each noted expectation when its result appears; also the timeout
    always @(posedge clk) begin
        hist <= {hist[8:0], main_alarm_lamp};
        cycles <= cycles + 1;
        if (chk_req) begin
            ent = pq.pop_front();
            check("outputs", {15'h0, obs & ent[33:17]}, {15'h0, ent[16:0]});
        end
        if (avs_read && avs_waitrequest === 1'b0) begin
            check("readdata", avs_readdata, rq.pop_front());
        end
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        pin_cmd[PIN_CPU_A] = 1'b1;
        pin_cmd[PIN_CPU_B] = 1'b1;
        pin_cmd[PIN_TEMP_LSB +: TEMP_W] = 8'h20;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, CONTROL_OFFSET, 32'h0, 4'h0, 32'h00005001);
        bus(1'b0, 4'hC, 32'h0, 4'h0, 32'h0);
        drive(PIN_ACK, 1'b0);
        expect_now('1, ex(0, 0, 5'h00, 0));
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            drive(src[i], 1'b1);
            expect_now('1, ex(1, 1, lmp[i], 0));
            drive(src[i], 1'b0);
            expect_now('1, ex(0, 0, 5'h00, 0));
        end
        $display("test sources done");
        bus(1'b1, CONTROL_OFFSET, 32'h00003000, 4'h2, 32'h0);
        pin_cmd[PIN_TEMP_LSB +: TEMP_W] <= 8'h30;
        drive(PIN_ACK, 1'b0);
        expect_now('1, ex(0, 0, 5'h00, 0));
        pin_cmd[PIN_TEMP_LSB +: TEMP_W] <= 8'h31;
        drive(PIN_ACK, 1'b0);
        expect_now(17'h1F83F, ex(1, 1, 5'h00, 0));
        pin_cmd[PIN_TEMP_LSB +: TEMP_W] <= 8'h20;
        drive(PIN_CPU_B, 1'b0);
        expect_now('1, ex(1, 1, 5'h10, 0));
        drive(PIN_CPU_B, 1'b1);
        bus(1'b1, CONTROL_OFFSET, 32'h00003000, 4'h1, 32'h0);
        bus(1'b0, CONTROL_OFFSET, 32'h0, 4'h0, 32'h00003000);
        drive(PIN_CPU_A, 1'b0);
        expect_now('1, ex(0, 0, 5'h00, 0));
        drive(PIN_CPU_A, 1'b1);
        $display("test cpu and frame done");
        drive(PIN_SUP1_LOW, 1'b1);
        ack();
        expect_now('1, ex(1, 0, 5'h04, 0));
        drive(PIN_FAN1_STOP, 1'b1);
        expect_now('1, ex(1, 0, 5'h0C, 0));
        drive(PIN_SUP1_LOW, 1'b0);
        expect_now('1, ex(1, 1, 5'h08, 0));
        drive(PIN_FAN1_STOP, 1'b0);
        $display("test acknowledge done");
        drive(PIN_SUP2_LOW, 1'b1);
        ack();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        expect_now(17'h07FFF, 17'h0);
        rst <= 1'b0;
        drive(PIN_ACK, 1'b0);
        expect_now('1, ex(1, 1, 5'h02, 0));
        drive(PIN_SUP2_LOW, 1'b0);
        drive(PIN_SUP_HOT, 1'b1);
        expect_now('1, ex(0, 0, 5'h01, 1));
        drive(PIN_SUP_HOT, 1'b0);
        expect_now('1, ex(0, 0, 5'h00, 0));
        $display("test reset and fan done");
        summarize();
    end
endmodule
